// >>> src/spd_pkg.sv
// Constants, field positions and register map of the scan process data framer
package spd_pkg;
  // ----------------------------------------------------------------
  // Image geometry and character FIFO size
  // ----------------------------------------------------------------
  localparam int IMG_BYTES  = 32;
  localparam int DATA_BYTES = 31;
  localparam int EXTRA_NUM  = 6;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = 8;
  // ----------------------------------------------------------------
  // Status byte and output image byte bit positions
  // ----------------------------------------------------------------
  localparam int ST_READY  = 0;
  localparam int ST_GOOD   = 1;
  localparam int ST_NOREAD = 2;
  localparam int ST_OVR    = 3;
  localparam int ST_RSVD   = 4;
  localparam int ST_TRIG   = 5;
  localparam int ST_EXTIN  = 6;
  localparam int ST_TOGGLE = 7;
  localparam int PDO_TRIG  = 0;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_EXTRA  = 8'h04;
  localparam logic [7:0] ADDR_MAXLEN = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [1:0] RST_SRC     = 2'h0;
  localparam logic [5:0] RST_EXTRA   = 6'h00;
  localparam logic [7:0] RST_MAXLEN  = 8'h00;
  // ----------------------------------------------------------------
  // Trigger source codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_PD   = 2'h0;
  localparam logic [1:0] SRC_EXT  = 2'h1;
  localparam logic [1:0] SRC_AUTO = 2'h2;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 25;
  localparam int AUTO_PERIOD_US = 1000;
  localparam int AUTO_ON_US     = 500;
  localparam int AUTO_PERIOD_CYC = AUTO_PERIOD_US * CLK_MHZ;
  localparam int AUTO_ON_CYC     = AUTO_ON_US * CLK_MHZ;
  // ----------------------------------------------------------------
  // Framer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_DRAIN   = 4'b0010,
    ST_EXTRAS  = 4'b0100,
    ST_PUBLISH = 4'b1000
  } spd_state_e;
endpackage : spd_pkg

// >>> src/spd_fifo.sv
// Character FIFO between the decoder and the framer
`timescale 1ns/1ps
module spd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,       // Clock
  input  wire logic             rst,       // Async reset, high
  input  wire logic             in_valid,  // Write request
  input  wire logic [WIDTH-1:0] in_data,   // Write data
  output logic                  in_ready,  // Room available
  output logic                  out_valid, // Read data valid
  output logic      [WIDTH-1:0] out_data,  // Registered read data
  input  wire logic             out_ready  // Consumer takes word
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
  logic [CW-1:0]    cnt_ff, nxt_cnt;
  logic             ready_ff, nxt_ready, valid_ff, nxt_valid;
  logic [WIDTH-1:0] data_ff, nxt_data;
  logic             push, load;

  assign in_ready  = ready_ff;
  assign out_valid = valid_ff;
  assign out_data  = data_ff;

  always_comb begin
    push       = in_valid && ready_ff;
    load       = (cnt_ff != '0) && (!valid_ff || out_ready);
    nxt_wr_ptr = push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
    nxt_rd_ptr = load ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
    nxt_cnt    = CW'(cnt_ff + CW'(push) - CW'(load));
    nxt_ready  = nxt_cnt != FULL_CNT;
    nxt_valid  = load ? 1'b1 : (out_ready ? 1'b0 : valid_ff);
    nxt_data   = load ? mem[rd_ptr_ff] : data_ff;
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
      ready_ff  <= 1'b0;
      valid_ff  <= 1'b0;
      data_ff   <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      cnt_ff    <= nxt_cnt;
      ready_ff  <= nxt_ready;
      valid_ff  <= nxt_valid;
      data_ff   <= nxt_data;
    end
  end
endmodule : spd_fifo

// >>> src/spd_framer.sv
// Process data image framer: trigger selection, laser enable and input image assembly
`timescale 1ns/1ps
module spd_framer #(
  parameter int AUTO_PERIOD_CYC = spd_pkg::AUTO_PERIOD_CYC,
  parameter int AUTO_ON_CYC     = spd_pkg::AUTO_ON_CYC
) (
  input  wire logic         REF_CLK,     // 25 MHz clock
  input  wire logic         RESET,       // Async reset, high
  input  wire logic [7:0]   PDO_BYTE,    // Output image from master
  input  wire logic         PDO_VALID,   // Output image update strobe
  output logic      [255:0] PDI_IMAGE,   // Input image to master
  input  wire logic         EXT_TRIG,    // External trigger pin
  input  wire logic         DEV_OK,      // Device operational pin
  output logic              LASER_ON,    // Laser emitter enable
  input  wire logic         DEC_VALID,   // Decoder character valid
  input  wire logic [7:0]   DEC_CHAR,    // Decoder character
  output logic              DEC_READY,   // Character FIFO has room
  input  wire logic         DEC_DONE,    // Read cycle finished pulse
  input  wire logic         DEC_GOOD,    // Read cycle succeeded
  input  wire logic [7:0]   DEC_LEN,     // Characters pushed this cycle
  input  wire logic [47:0]  DEC_EXTRA,   // Six extra item bytes, item 0 low
  input  wire logic [7:0]   REG_ADDR,    // Register byte address
  input  wire logic [31:0]  REG_WDATA,   // Register write data
  input  wire logic         REG_WR,      // Register write strobe
  input  wire logic         REG_RD,      // Register read strobe
  output logic      [31:0]  REG_RDATA    // Register read data
);
  localparam int CNT_W = $clog2(AUTO_PERIOD_CYC + 1);
  localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(AUTO_PERIOD_CYC - 1);
  localparam logic [CNT_W-1:0] ON_CYC      = CNT_W'(AUTO_ON_CYC);
  localparam logic [7:0] DATA_MAX  = 8'(spd_pkg::DATA_BYTES);
  localparam logic [2:0] EXTRA_LST = 3'(spd_pkg::EXTRA_NUM - 1);
  localparam int DW = spd_pkg::DATA_BYTES * 8;
  // ----------------------------------------------------------------
  // Input synchronisers and master trigger
  // ----------------------------------------------------------------
  logic [1:0] sync1_ff, sync2_ff;
  logic       pd_trig_ff, nxt_pd_trig;

  always_comb begin
    nxt_pd_trig = PDO_VALID ? PDO_BYTE[spd_pkg::PDO_TRIG] : pd_trig_ff;
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      sync1_ff   <= 2'h0;
      sync2_ff   <= 2'h0;
      pd_trig_ff <= 1'b0;
    end else begin
      sync1_ff   <= {DEV_OK, EXT_TRIG};
      sync2_ff   <= sync1_ff;
      pd_trig_ff <= nxt_pd_trig;
    end
  end
  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [1:0]  src_ff, nxt_src;
  logic [5:0]  xmask_ff, nxt_xmask;
  logic [7:0]  maxlen_ff, nxt_maxlen;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [7:0]  stat_ff, nxt_stat;
  spd_pkg::spd_state_e state_ff, nxt_state;

  always_comb begin
    nxt_src    = src_ff;
    nxt_xmask  = xmask_ff;
    nxt_maxlen = maxlen_ff;
    nxt_rdata  = 32'h0;
    if (REG_WR) begin
      unique case (REG_ADDR)
        spd_pkg::ADDR_CTRL:   nxt_src    = REG_WDATA[1:0];
        spd_pkg::ADDR_EXTRA:  nxt_xmask  = REG_WDATA[5:0];
        spd_pkg::ADDR_MAXLEN: nxt_maxlen = REG_WDATA[7:0];
        default:              nxt_src    = src_ff;
      endcase
    end
    if (REG_RD) begin
      unique case (REG_ADDR)
        spd_pkg::ADDR_CTRL:   nxt_rdata = {30'h0, src_ff};
        spd_pkg::ADDR_EXTRA:  nxt_rdata = {26'h0, xmask_ff};
        spd_pkg::ADDR_MAXLEN: nxt_rdata = {24'h0, maxlen_ff};
        spd_pkg::ADDR_STATUS: nxt_rdata = {23'h0, state_ff != spd_pkg::ST_IDLE, stat_ff};
        default:              nxt_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      src_ff    <= spd_pkg::RST_SRC;
      xmask_ff  <= spd_pkg::RST_EXTRA;
      maxlen_ff <= spd_pkg::RST_MAXLEN;
      rdata_ff  <= 32'h0;
    end else begin
      src_ff    <= nxt_src;
      xmask_ff  <= nxt_xmask;
      maxlen_ff <= nxt_maxlen;
      rdata_ff  <= nxt_rdata;
    end
  end

  assign REG_RDATA = rdata_ff;
  // ----------------------------------------------------------------
  // Trigger selection, auto cycling and laser
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] auto_cnt_ff, nxt_auto_cnt;
  logic             laser_ff, nxt_laser;

  always_comb begin
    nxt_auto_cnt = (auto_cnt_ff == PERIOD_LAST) ? '0 : CNT_W'(auto_cnt_ff + 1'b1);
    unique case (src_ff)
      spd_pkg::SRC_PD:   nxt_laser = pd_trig_ff;
      spd_pkg::SRC_EXT:  nxt_laser = sync2_ff[0];
      spd_pkg::SRC_AUTO: nxt_laser = auto_cnt_ff < ON_CYC;
      default:           nxt_laser = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      auto_cnt_ff <= '0;
      laser_ff    <= 1'b0;
    end else begin
      auto_cnt_ff <= nxt_auto_cnt;
      laser_ff    <= nxt_laser;
    end
  end

  assign LASER_ON = laser_ff;
  // ----------------------------------------------------------------
  // Character FIFO
  // ----------------------------------------------------------------
  logic       fifo_valid, fifo_take;
  logic [7:0] fifo_char;

  spd_fifo #(
    .WIDTH (spd_pkg::FIFO_WIDTH),
    .DEPTH (spd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (REF_CLK),
    .rst       (RESET),
    .in_valid  (DEC_VALID),
    .in_data   (DEC_CHAR),
    .in_ready  (DEC_READY),
    .out_valid (fifo_valid),
    .out_data  (fifo_char),
    .out_ready (fifo_take)
  );
  // ----------------------------------------------------------------
  // Result framing
  // ----------------------------------------------------------------
  logic          pend_ff, nxt_pend, cgood_ff, nxt_cgood, wgood_ff, nxt_wgood;
  logic [7:0]    clen_ff, nxt_clen, rem_ff, nxt_rem, chars_ff, nxt_chars, pos_ff, nxt_pos;
  logic [47:0]   cext_ff, nxt_cext, wext_ff, nxt_wext;
  logic [2:0]    idx_ff, nxt_idx;
  logic          ovr_ff, nxt_ovr;
  logic [DW-1:0] build_ff, nxt_build, data_ff, nxt_data;
  logic          put_en;
  logic [7:0]    put_byte;

  always_comb begin
    nxt_state = state_ff;
    nxt_pend  = DEC_DONE | pend_ff;
    nxt_cgood = DEC_DONE ? DEC_GOOD : cgood_ff;
    nxt_clen  = DEC_DONE ? DEC_LEN : clen_ff;
    nxt_cext  = DEC_DONE ? DEC_EXTRA : cext_ff;
    nxt_wgood = wgood_ff;
    nxt_wext  = wext_ff;
    nxt_rem   = rem_ff;
    nxt_chars = chars_ff;
    nxt_pos   = pos_ff;
    nxt_idx   = idx_ff;
    nxt_ovr   = ovr_ff;
    nxt_build = build_ff;
    nxt_data  = data_ff;
    fifo_take = 1'b0;
    put_en    = 1'b0;
    put_byte  = 8'h0;
    unique case (state_ff)
      spd_pkg::ST_IDLE: begin
        if (pend_ff) begin
          nxt_pend  = DEC_DONE;
          nxt_wgood = cgood_ff;
          nxt_wext  = cext_ff;
          nxt_rem   = clen_ff;
          nxt_chars = 8'h0;
          nxt_pos   = 8'h0;
          nxt_ovr   = 1'b0;
          nxt_build = '0;
          nxt_state = spd_pkg::ST_DRAIN;
        end
      end
      spd_pkg::ST_DRAIN: begin
        if (rem_ff == 8'h0) begin
          nxt_idx   = 3'h0;
          nxt_state = spd_pkg::ST_EXTRAS;
        end else begin
          fifo_take = 1'b1;
          if (fifo_valid) begin
            nxt_rem = 8'(rem_ff - 1'b1);
            if ((maxlen_ff == 8'h0) || (chars_ff < maxlen_ff)) begin
              put_en    = 1'b1;
              put_byte  = fifo_char;
              nxt_chars = 8'(chars_ff + 1'b1);
            end
          end
        end
      end
      spd_pkg::ST_EXTRAS: begin
        put_en   = xmask_ff[idx_ff];
        put_byte = wext_ff[idx_ff*8 +: 8];
        nxt_idx  = 3'(idx_ff + 1'b1);
        if (idx_ff == EXTRA_LST) begin
          nxt_state = spd_pkg::ST_PUBLISH;
        end
      end
      spd_pkg::ST_PUBLISH: begin
        nxt_data  = build_ff;
        nxt_state = spd_pkg::ST_IDLE;
      end
      default: nxt_state = spd_pkg::ST_IDLE;
    endcase
    if (put_en) begin
      if (pos_ff < DATA_MAX) begin
        nxt_build[pos_ff*8 +: 8] = put_byte;
        nxt_pos = 8'(pos_ff + 1'b1);
      end else begin
        nxt_ovr = 1'b1;
      end
    end
  end
  // ----------------------------------------------------------------
  // Status byte
  // ----------------------------------------------------------------
  always_comb begin
    nxt_stat                    = stat_ff;
    nxt_stat[spd_pkg::ST_READY] = sync2_ff[1];
    nxt_stat[spd_pkg::ST_RSVD]  = 1'b0;
    nxt_stat[spd_pkg::ST_TRIG]  = nxt_laser;
    nxt_stat[spd_pkg::ST_EXTIN] = sync2_ff[0];
    if (state_ff == spd_pkg::ST_PUBLISH) begin
      nxt_stat[spd_pkg::ST_GOOD]   = wgood_ff;
      nxt_stat[spd_pkg::ST_NOREAD] = !wgood_ff;
      nxt_stat[spd_pkg::ST_OVR]    = ovr_ff;
      nxt_stat[spd_pkg::ST_TOGGLE] = !stat_ff[spd_pkg::ST_TOGGLE];
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      state_ff <= spd_pkg::ST_IDLE;
      pend_ff  <= 1'b0;
      cgood_ff <= 1'b0;
      wgood_ff <= 1'b0;
      clen_ff  <= 8'h0;
      rem_ff   <= 8'h0;
      chars_ff <= 8'h0;
      pos_ff   <= 8'h0;
      cext_ff  <= 48'h0;
      wext_ff  <= 48'h0;
      idx_ff   <= 3'h0;
      ovr_ff   <= 1'b0;
      build_ff <= '0;
      data_ff  <= '0;
      stat_ff  <= 8'h0;
    end else begin
      state_ff <= nxt_state;
      pend_ff  <= nxt_pend;
      cgood_ff <= nxt_cgood;
      wgood_ff <= nxt_wgood;
      clen_ff  <= nxt_clen;
      rem_ff   <= nxt_rem;
      chars_ff <= nxt_chars;
      pos_ff   <= nxt_pos;
      cext_ff  <= nxt_cext;
      wext_ff  <= nxt_wext;
      idx_ff   <= nxt_idx;
      ovr_ff   <= nxt_ovr;
      build_ff <= nxt_build;
      data_ff  <= nxt_data;
      stat_ff  <= nxt_stat;
    end
  end

  assign PDI_IMAGE = {data_ff, stat_ff};
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  a_result_exclusive: assert property (!(stat_ff[spd_pkg::ST_GOOD] && stat_ff[spd_pkg::ST_NOREAD]))
    else $error("good and no read both set");
  a_reserved_zero: assert property (stat_ff[spd_pkg::ST_RSVD] == 1'b0)
    else $error("reserved status bit set");
  a_laser_trig_state: assert property (LASER_ON == stat_ff[spd_pkg::ST_TRIG])
    else $error("laser and trigger state differ");
  a_toggle_on_publish: assert property (state_ff == spd_pkg::ST_PUBLISH |=>
      stat_ff[spd_pkg::ST_TOGGLE] != $past(stat_ff[spd_pkg::ST_TOGGLE]))
    else $error("toggle missed on publish");
  a_toggle_held: assert property (state_ff != spd_pkg::ST_PUBLISH |=> $stable(stat_ff[spd_pkg::ST_TOGGLE]))
    else $error("toggle changed without publish");
  a_ready_follow: assert property (DEV_OK [*4] |-> stat_ff[spd_pkg::ST_READY])
    else $error("device ready not shown");
  a_ext_mirror: assert property (EXT_TRIG [*4] |-> stat_ff[spd_pkg::ST_EXTIN])
    else $error("external input not mirrored");
  a_pd_trigger_laser: assert property (src_ff == spd_pkg::SRC_PD && PDO_VALID && PDO_BYTE[0] ##1
      (src_ff == spd_pkg::SRC_PD && !PDO_VALID) |=> LASER_ON)
    else $error("process data trigger did not start laser");
  a_ext_src_laser: assert property ((src_ff == spd_pkg::SRC_EXT && !EXT_TRIG) [*4] |-> !LASER_ON)
    else $error("laser on without external trigger");
  a_overrun_flag: assert property (state_ff == spd_pkg::ST_PUBLISH |=> stat_ff[spd_pkg::ST_OVR] == $past(ovr_ff))
    else $error("overrun flag wrong");
  a_data_bound: assert property (pos_ff <= DATA_MAX)
    else $error("data position beyond field");
  a_max_length: assert property (state_ff == spd_pkg::ST_DRAIN && maxlen_ff != 8'h0 |-> chars_ff <= maxlen_ff)
    else $error("truncation exceeded");
  a_publish_bound: assert property (state_ff == spd_pkg::ST_EXTRAS |-> ##[1:6] state_ff == spd_pkg::ST_PUBLISH)
    else $error("extras did not finish");

  c_good_read: cover property (state_ff == spd_pkg::ST_PUBLISH && wgood_ff);
  c_no_read: cover property (state_ff == spd_pkg::ST_PUBLISH && !wgood_ff);
  c_overrun: cover property (state_ff == spd_pkg::ST_PUBLISH && ovr_ff);
  c_auto_laser: cover property (src_ff == spd_pkg::SRC_AUTO && LASER_ON);
endmodule : spd_framer

// >>> tb/spd_master_model.sv
// Master side model: sends the output image byte and samples the input image
`timescale 1ns/1ps
module spd_master_model (
  input  wire logic         clk,       // Clock
  input  wire logic         rst,       // Async reset, high
  input  wire logic         send,      // Send one output image
  input  wire logic [7:0]   out_byte,  // Output image to send
  input  wire logic [255:0] in_image,  // Input image from device
  output logic      [7:0]   pdo_byte,  // Output image byte
  output logic              pdo_valid, // Output image strobe
  output logic      [7:0]   status_ff  // Last status byte seen
);
  // Byte line carries a changing pattern between updates
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pdo_byte  <= 8'h00;
      pdo_valid <= 1'b0;
      status_ff <= 8'h00;
    end else begin
      pdo_valid <= send;
      pdo_byte  <= send ? out_byte : ~pdo_byte;
      status_ff <= in_image[7:0];
    end
  end
endmodule : spd_master_model

// >>> tb/spd_framer_tb_top.sv
// Self-checking testbench of the process data framer
`timescale 1ns/1ps
module spd_framer_tb_top;
  localparam int AUTO_P  = 20;
  localparam int AUTO_ON = 10;
  logic         ref_clk, reset, ext_trig, dev_ok, laser_on, send;
  logic         dec_valid, dec_ready, dec_done, dec_good, reg_wr, reg_rd, pdo_valid;
  logic [7:0]   dec_char, dec_len, reg_addr, pdo_byte, out_byte, m_status;
  logic [47:0]  dec_extra;
  logic [31:0]  reg_wdata, reg_rdata;
  logic [255:0] pdi_image;
  logic         tog;
  int           num_errors, compares;

  spd_framer #(.AUTO_PERIOD_CYC(AUTO_P), .AUTO_ON_CYC(AUTO_ON)) i_spd_framer (
    .REF_CLK(ref_clk), .RESET(reset), .PDO_BYTE(pdo_byte), .PDO_VALID(pdo_valid),
    .PDI_IMAGE(pdi_image), .EXT_TRIG(ext_trig), .DEV_OK(dev_ok), .LASER_ON(laser_on),
    .DEC_VALID(dec_valid), .DEC_CHAR(dec_char), .DEC_READY(dec_ready), .DEC_DONE(dec_done),
    .DEC_GOOD(dec_good), .DEC_LEN(dec_len), .DEC_EXTRA(dec_extra), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));

  spd_master_model i_spd_master_model (
    .clk(ref_clk), .rst(reset), .send(send), .out_byte(out_byte), .in_image(pdi_image),
    .pdo_byte(pdo_byte), .pdo_valid(pdo_valid), .status_ff(m_status));

  always #20 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("Totals: compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      num_errors++;
      close_out();
    end
  endtask : guard

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd

  task automatic pd_send(input logic [7:0] b);
    @(posedge ref_clk);
    send     <= 1'b1;
    out_byte <= b;
    @(posedge ref_clk);
    send     <= 1'b0;
    tick(6);
  endtask : pd_send

  task automatic set_ext(input logic v);
    @(posedge ref_clk);
    ext_trig <= v;
    tick(6);
  endtask : set_ext

  task automatic img(input logic [255:0] exp);
    for (int k = 0; k < 8; k++) chk(pdi_image[32*k +: 32], exp[32*k +: 32]);
  endtask : img

  // Pushes len characters from 0x41 up, ends the read and waits for the result
  task automatic read_case(input logic good, input int len, input logic [247:0] dat, input logic ovr);
    int n;
    logic old;
    for (int i = 0; i < len; i++) begin
      @(posedge ref_clk);
      dec_valid <= 1'b1;
      dec_char  <= 8'h41 + i[7:0];
      n = 0;
      do begin @(posedge ref_clk); n++; end while (dec_ready !== 1'b1 && n < 100);
      dec_valid <= 1'b0;
      guard(n, 100);
    end
    tick(2);
    chk({31'h0, dec_ready}, {31'h0, len <= spd_pkg::FIFO_DEPTH});
    old = pdi_image[7];
    @(posedge ref_clk);
    dec_done  <= 1'b1;
    dec_good  <= good;
    dec_len   <= len[7:0];
    dec_extra <= 48'h665544332211;
    @(posedge ref_clk);
    dec_done  <= 1'b0;
    n = 0;
    while (pdi_image[7] === old && n < 300) begin tick(1); n++; end
    guard(n, 300);
    tog = ~tog;
    tick(2);
    img({dat, tog, 3'b000, ovr, ~good, good, 1'b1});
  endtask : read_case

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    img({248'h0, 8'h01});
    rd(spd_pkg::ADDR_CTRL, 32'h0);
    rd(spd_pkg::ADDR_EXTRA, 32'h0);
    rd(spd_pkg::ADDR_MAXLEN, 32'h0);
    wr(spd_pkg::ADDR_STATUS, 32'hff);
    wr(8'h10, 32'h3);
    rd(8'h10, 32'h0);
    rd(spd_pkg::ADDR_STATUS, 32'h1);
    @(posedge ref_clk);
    dev_ok <= 1'b0;
    tick(6);
    chk({24'h0, m_status}, 32'h0);
    @(posedge ref_clk);
    dev_ok <= 1'b1;
    tick(6);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_pd();
    pd_send(8'hfe);
    chk({31'h0, laser_on}, 32'h0);
    chk({24'h0, m_status}, 32'h01);
    pd_send(8'h01);
    chk({31'h0, laser_on}, 32'h1);
    chk({24'h0, m_status}, 32'h21);
    pd_send(8'h00);
    set_ext(1'b1);
    chk({31'h0, laser_on}, 32'h0);
    chk({24'h0, m_status}, 32'h41);
    $display("t_pd done");
  endtask : t_pd

  task automatic t_src();
    int cnt;
    wr(spd_pkg::ADDR_CTRL, {30'h0, spd_pkg::SRC_EXT});
    tick(4);
    chk({31'h0, laser_on}, 32'h1);
    chk({24'h0, m_status}, 32'h61);
    set_ext(1'b0);
    chk({31'h0, laser_on}, 32'h0);
    wr(spd_pkg::ADDR_CTRL, 32'h3);
    set_ext(1'b1);
    chk({31'h0, laser_on}, 32'h0);
    set_ext(1'b0);
    wr(spd_pkg::ADDR_CTRL, {30'h0, spd_pkg::SRC_AUTO});
    tick(50);
    cnt = 0;
    for (int i = 0; i < 2 * AUTO_P; i++) begin tick(1); cnt += int'(laser_on === 1'b1); end
    chk(cnt, 2 * AUTO_ON);
    wr(spd_pkg::ADDR_CTRL, 32'h3);
    $display("t_src done");
  endtask : t_src

  task automatic t_read();
    logic [247:0] d;
    read_case(1'b1, 3, {224'h0, 24'h434241}, 1'b0);
    rd(spd_pkg::ADDR_STATUS, {24'h0, tog, 7'h03});
    wr(spd_pkg::ADDR_MAXLEN, 32'h2);
    wr(spd_pkg::ADDR_EXTRA, 32'h05);
    read_case(1'b1, 3, {216'h0, 32'h33114241}, 1'b0);
    wr(spd_pkg::ADDR_MAXLEN, 32'h0);
    wr(spd_pkg::ADDR_EXTRA, 32'h0);
    for (int k = 0; k < 31; k++) d[8*k +: 8] = 8'h41 + k[7:0];
    read_case(1'b1, 32, d, 1'b1);
    read_case(1'b0, 0, 248'h0, 1'b0);
    $display("t_read done");
  endtask : t_read

  initial begin
    ref_clk = 1'b0; reset = 1'b1; ext_trig = 1'b0; dev_ok = 1'b1; send = 1'b0;
    out_byte = 8'h00; dec_valid = 1'b0; dec_char = 8'h00; dec_done = 1'b0; dec_good = 1'b0;
    dec_len = 8'h00; dec_extra = 48'h0; reg_addr = 8'h00; reg_wdata = 32'h0; reg_wr = 1'b0;
    reg_rd = 1'b0; tog = 1'b0; num_errors = 0; compares = 0;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    tick(6);
    t_reset();
    t_pd();
    t_src();
    t_read();
    close_out();
  end
endmodule : spd_framer_tb_top
